//--- rtl/dgp_pkg.sv
// package: register map, widths and reset values for the dual gpio port block
package dgp_pkg;
	localparam int PB_W = 15;
	localparam int PC_W = 12;
	localparam int AW   = 3;
	localparam int DW   = 16;
	localparam logic [2:0] OFF_PB_FSEL = 3'h0;
	localparam logic [2:0] OFF_PB_DIR  = 3'h1;
	localparam logic [2:0] OFF_PB_DATA = 3'h2;
	localparam logic [2:0] OFF_PC_FSEL = 3'h3;
	localparam logic [2:0] OFF_PC_DIR  = 3'h4;
	localparam logic [2:0] OFF_PC_DATA = 3'h5;
	localparam logic        RST_PB_FSEL = 1'h0;
	localparam logic [14:0] RST_PB_DIR  = 15'h0000;
	localparam logic [14:0] RST_PB_DATA = 15'h0000;
	localparam logic [11:0] RST_PC_FSEL = 12'h000;
	localparam logic [11:0] RST_PC_DIR  = 12'h000;
	localparam logic [11:0] RST_PC_DATA = 12'h000;
endpackage

//--- rtl/dgp_port.sv
// dual gpio port: two programmable pin ports shared with on-chip peripherals
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// How it works
// [RL1] second port has a 12-bit select, one bit per pin, gpio or peripheral
// [RL2] first port select is one bit switching all fifteen pins together
// [RL3] first port has fifteen pins, else carrying host parallel interface signals
// [RL4] second port has twelve pins, else serving timer and two serial interfaces
// [RL5] each port has a direction register, one bit per pin
// [RL6] each port has a data register driving outputs and reading inputs
// [RL7] select, direction and data registers are readable and writable
// [RL8] only these 27 pins are programmable; codec and bus pins are excluded
// [RL9] gpio output pins drive data bit; input data reads sampled pin level
// [RL10] reset clears select and direction, so all pins start as gpio inputs
module dgp_port
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic [14:0] pb_in,
	output logic      [14:0] pb_out,
	output logic      [14:0] pb_oe,
	input  wire logic [14:0] host_out,
	input  wire logic [14:0] host_oe,
	output logic      [14:0] host_in,
	input  wire logic [11:0] pc_in,
	output logic      [11:0] pc_out,
	output logic      [11:0] pc_oe,
	input  wire logic [11:0] periph_out,
	input  wire logic [11:0] periph_oe,
	output logic      [11:0] periph_in
);
	logic        pb_fsel_r;
	logic [14:0] pb_dir_r;
	logic [14:0] pb_data_r;
	logic [11:0] pc_fsel_r;
	logic [11:0] pc_dir_r;
	logic [11:0] pc_data_r;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic [14:0] pb_gpio_oe;
	logic [11:0] pc_gpio_oe;
	logic [14:0] pb_read;
	logic [11:0] pc_read;

	wire we_pb_fsel = wr && (addr == dgp_pkg::OFF_PB_FSEL);
	wire we_pb_dir  = wr && (addr == dgp_pkg::OFF_PB_DIR);
	wire we_pb_data = wr && (addr == dgp_pkg::OFF_PB_DATA);
	wire we_pc_fsel = wr && (addr == dgp_pkg::OFF_PC_FSEL);
	wire we_pc_dir  = wr && (addr == dgp_pkg::OFF_PC_DIR);
	wire we_pc_data = wr && (addr == dgp_pkg::OFF_PC_DATA);

	// register writes; reset leaves every pin a gpio input
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pb_fsel_r <= dgp_pkg::RST_PB_FSEL; // RL10
		else if (we_pb_fsel)
			pb_fsel_r <= wdata[0]; // RL2
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pb_dir_r <= dgp_pkg::RST_PB_DIR; // RL10
		else if (we_pb_dir)
			pb_dir_r <= wdata[14:0]; // RL5
	end

	// data latches reset too, so a pin turned to output first drives a known low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pb_data_r <= dgp_pkg::RST_PB_DATA;
		else if (we_pb_data)
			pb_data_r <= wdata[14:0]; // RL6
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_fsel_r <= dgp_pkg::RST_PC_FSEL; // RL10
		else if (we_pc_fsel)
			pc_fsel_r <= wdata[11:0]; // RL1
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_dir_r <= dgp_pkg::RST_PC_DIR; // RL10
		else if (we_pc_dir)
			pc_dir_r <= wdata[11:0]; // RL5
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_data_r <= dgp_pkg::RST_PC_DATA;
		else if (we_pc_data)
			pc_data_r <= wdata[11:0]; // RL6
	end

	// first port: one select bit moves all fifteen pins to the host interface
	assign pb_gpio_oe = pb_dir_r;
	assign pb_out     = pb_fsel_r ? host_out : pb_data_r; // RL3 RL9
	assign pb_oe      = pb_fsel_r ? host_oe : pb_gpio_oe; // RL2 RL9
	// peripheral sees pin level only while it owns the pins, else idle low
	assign host_in    = pb_fsel_r ? pb_in : 15'h0000; // RL3

	// second port: per-pin choice between gpio and timer/serial functions
	assign pc_gpio_oe = pc_dir_r;
	genvar gi;
	generate
		for (gi = 0; gi < dgp_pkg::PC_W; gi++)
		begin : g_pc
			assign pc_out[gi]    = pc_fsel_r[gi] ? periph_out[gi] : pc_data_r[gi]; // RL4 RL9
			assign pc_oe[gi]     = pc_fsel_r[gi] ? periph_oe[gi] : pc_gpio_oe[gi]; // RL1
			assign periph_in[gi] = pc_fsel_r[gi] & pc_in[gi]; // RL4
		end
	endgenerate

	// data reads: output bits return the latch, input bits the pin level
	assign pb_read = (pb_data_r & pb_dir_r) | (pb_in & ~pb_dir_r); // RL9
	assign pc_read = (pc_data_r & pc_dir_r) | (pc_in & ~pc_dir_r); // RL9

	// only the 27 port pins are reachable; other offsets read as zero
	always_comb
	begin
		rdata_nxt = 16'h0000;
		unique case (addr)
			dgp_pkg::OFF_PB_FSEL: rdata_nxt = {15'h0000, pb_fsel_r}; // RL7
			dgp_pkg::OFF_PB_DIR:  rdata_nxt = {1'h0, pb_dir_r}; // RL7
			dgp_pkg::OFF_PB_DATA: rdata_nxt = {1'h0, pb_read}; // RL7
			dgp_pkg::OFF_PC_FSEL: rdata_nxt = {4'h0, pc_fsel_r}; // RL7
			dgp_pkg::OFF_PC_DIR:  rdata_nxt = {4'h0, pc_dir_r}; // RL7
			dgp_pkg::OFF_PC_DATA: rdata_nxt = {4'h0, pc_read}; // RL7
			default:              rdata_nxt = 16'h0000; // RL8
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_r <= 16'h0000;
		else if (rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= 16'h0000;
	end
	assign rdata = rdata_r;

	// checks
	pc_sel_a: assert property (@(posedge clk) disable iff (rst) // RL1
		(!pc_fsel_r[0]) |-> (pc_oe[0] == pc_dir_r[0] && pc_out[0] == pc_data_r[0]))
		else $error("port c pin 0 not under gpio control");
	pb_sel_a: assert property (@(posedge clk) disable iff (rst) // RL2
		we_pb_fsel |=> (pb_fsel_r == $past(wdata[0])))
		else $error("port b select not written");
	pb_host_a: assert property (@(posedge clk) disable iff (rst) // RL3
		pb_fsel_r |-> (pb_oe == host_oe && pb_out == host_out && host_in == pb_in))
		else $error("port b not handed to host interface");
	pc_periph_a: assert property (@(posedge clk) disable iff (rst) // RL4
		(pc_out & pc_fsel_r) == (periph_out & pc_fsel_r))
		else $error("port c not handed to peripherals");
	pc_periph_oe_a: assert property (@(posedge clk) disable iff (rst) // RL4
		(pc_oe & pc_fsel_r) == (periph_oe & pc_fsel_r))
		else $error("port c peripheral enable not passed");
	pc_in_gate_a: assert property (@(posedge clk) disable iff (rst) // RL4
		periph_in == (pc_in & pc_fsel_r))
		else $error("port c peripheral input not gated");
	pc_gpio_a: assert property (@(posedge clk) disable iff (rst) // RL1
		(pc_oe & ~pc_fsel_r) == (pc_dir_r & ~pc_fsel_r))
		else $error("port c gpio enable not from direction");
	pc_sel_wr_a: assert property (@(posedge clk) disable iff (rst) // RL1
		we_pc_fsel |=> (pc_fsel_r == $past(wdata[11:0])))
		else $error("port c select not written");
	pb_gpio_a: assert property (@(posedge clk) disable iff (rst) // RL2
		!pb_fsel_r |-> (pb_oe == pb_dir_r && pb_out == pb_data_r && host_in == 15'h0000))
		else $error("port b not under gpio control");
	dir_write_a: assert property (@(posedge clk) disable iff (rst) // RL5
		we_pc_dir |=> (pc_dir_r == $past(wdata[11:0])))
		else $error("port c direction not written");
	data_drive_a: assert property (@(posedge clk) disable iff (rst) // RL6
		(we_pb_data && !pb_fsel_r) ##1 !pb_fsel_r |-> ((pb_out & pb_oe) == ($past(wdata[14:0]) & pb_dir_r)))
		else $error("port b data not driven");
	read_back_a: assert property (@(posedge clk) disable iff (rst) // RL7
		(rd && addr == dgp_pkg::OFF_PC_DIR) |=> (rdata[11:0] == $past(pc_dir_r) && rdata[15:12] == 4'h0))
		else $error("port c direction read back wrong");
	unmapped_a: assert property (@(posedge clk) disable iff (rst) // RL8
		(rd && addr > dgp_pkg::OFF_PC_DATA) |=> (rdata == 16'h0000))
		else $error("unmapped read not zero");
	in_read_a: assert property (@(posedge clk) disable iff (rst) // RL9
		(rd && addr == dgp_pkg::OFF_PB_DATA && pb_dir_r == 15'h0000) |=> (rdata[14:0] == $past(pb_in)))
		else $error("port b input level not returned");
	reset_in_a: assert property (@(posedge clk) // RL10
		$fell(rst) |-> (pb_oe == 15'h0000 && pc_oe == 12'h000))
		else $error("pins not inputs after reset");
	reset_reg_a: assert property (@(posedge clk) // RL10
		$fell(rst) |-> (pb_fsel_r == dgp_pkg::RST_PB_FSEL && pc_fsel_r == dgp_pkg::RST_PC_FSEL))
		else $error("selects not cleared by reset");
	pb_dir_wr_a: assert property (@(posedge clk) disable iff (rst) // RL5
		we_pb_dir |=> (pb_dir_r == $past(wdata[14:0])))
		else $error("port b direction not written");
	pc_data_wr_a: assert property (@(posedge clk) disable iff (rst) // RL6
		we_pc_data |=> (pc_data_r == $past(wdata[11:0])))
		else $error("port c data not written");
	rdata_idle_a: assert property (@(posedge clk) disable iff (rst) // RL7
		!rd |=> (rdata == 16'h0000))
		else $error("read data not idle after no read");
	sel_read_a: assert property (@(posedge clk) disable iff (rst) // RL7
		(rd && addr == dgp_pkg::OFF_PB_FSEL) |=> (rdata == {15'h0000, $past(pb_fsel_r)}))
		else $error("port b select read back wrong");
	unmapped_wr_a: assert property (@(posedge clk) disable iff (rst) // RL8
		(wr && addr > dgp_pkg::OFF_PC_DATA) |=>
			($stable(pb_dir_r) && $stable(pb_data_r) && $stable(pc_dir_r) && $stable(pc_data_r)))
		else $error("unmapped write changed a register");
	pc_drive_a: assert property (@(posedge clk) disable iff (rst) // RL9
		(pc_out & pc_dir_r & ~pc_fsel_r) == (pc_data_r & pc_dir_r & ~pc_fsel_r))
		else $error("port c output pin not driven from data");
	pc_read_a: assert property (@(posedge clk) disable iff (rst) // RL9
		(rd && addr == dgp_pkg::OFF_PC_DATA) |=>
			(rdata[11:0] == (($past(pc_data_r) & $past(pc_dir_r)) | ($past(pc_in) & ~$past(pc_dir_r)))))
		else $error("port c data read back wrong");
endmodule

//--- bench/dgp_board.sv
// board model: pin level seen by the block, from its drive or the board
`timescale 1ns/10ps
module dgp_board
(
	input  wire logic [14:0] pb_out,
	input  wire logic [14:0] pb_oe,
	input  wire logic [14:0] pb_ext,
	output logic      [14:0] pb_in,
	input  wire logic [11:0] pc_out,
	input  wire logic [11:0] pc_oe,
	input  wire logic [11:0] pc_ext,
	output logic      [11:0] pc_in
);
	// a driven pin reads back its own drive, so board level never masks it
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
endmodule

//--- bench/tb_top.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/10ps
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic [14:0] pb_in, pb_out, pb_oe, host_in, pb_ext = 15'h0000;
	logic [14:0] host_out = 15'h1234, host_oe = 15'h00ff;
	logic [11:0] pc_in, pc_out, pc_oe, periph_in, pc_ext = 12'hfff;
	logic [11:0] periph_out = 12'h3c3, periph_oe = 12'h030;
	int          bad_count = 0;
	int          check_count = 0;
	always #20 clk = ~clk;
	dgp_port u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .host_out(host_out),
		.host_oe(host_oe), .host_in(host_in), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
		.periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));
	dgp_board u_board (.pb_out(pb_out), .pb_oe(pb_oe), .pb_ext(pb_ext), .pb_in(pb_in),
		.pc_out(pc_out), .pc_oe(pc_oe), .pc_ext(pc_ext), .pc_in(pc_in));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic t_reset;
		logic [15:0] e;
		// all pins are inputs now, so the data registers read the board level
		for (int i = 0; i < 8; i++)
		begin
			e = 16'h0000;
			if (i[2:0] == dgp_pkg::OFF_PB_DATA)
				e = 16'(pb_ext);
			if (i[2:0] == dgp_pkg::OFF_PC_DATA)
				e = 16'(pc_ext);
			rchk(i[2:0], e);
		end
		chk(16'(pb_oe), 16'h0000);
		chk(16'(pc_oe), 16'h0000);
		chk(16'(host_in), 16'h0000);
		chk(16'(periph_in), 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_port_b;
		wreg(dgp_pkg::OFF_PB_DIR, 16'hffff);
		wreg(dgp_pkg::OFF_PB_DATA, 16'h5555);
		chk(16'(pb_oe), 16'h7fff);
		chk(16'(pb_out), 16'h5555);
		rchk(dgp_pkg::OFF_PB_DIR, 16'h7fff);
		@(posedge clk);
		pb_ext <= 15'h2aaa;
		wreg(dgp_pkg::OFF_PB_DIR, 16'h00ff);
		rchk(dgp_pkg::OFF_PB_DATA, 16'h2a55);
		wreg(dgp_pkg::OFF_PB_FSEL, 16'hffff);
		chk(16'(pb_oe), 16'h00ff);
		chk(16'(pb_out), 16'h1234);
		chk(16'(host_in), 16'h2a34);
		rchk(dgp_pkg::OFF_PB_FSEL, 16'h0001);
		$display("test port b done");
	endtask
	task automatic t_port_c;
		wreg(dgp_pkg::OFF_PC_DIR, 16'h0fff);
		wreg(dgp_pkg::OFF_PC_DATA, 16'h0a5a);
		wreg(dgp_pkg::OFF_PC_FSEL, 16'hf0f0);
		chk(16'(pc_out), 16'h0aca);
		chk(16'(pc_oe), 16'h0f3f);
		chk(16'(periph_in), 16'h00c0);
		rchk(dgp_pkg::OFF_PC_FSEL, 16'h00f0);
		wreg(3'h6, 16'hffff);
		rchk(dgp_pkg::OFF_PC_DIR, 16'h0fff);
		rchk(dgp_pkg::OFF_PC_DATA, 16'h0a5a);
		wreg(dgp_pkg::OFF_PC_DIR, 16'h000f);
		chk(16'(pc_oe), 16'h003f);
		rchk(dgp_pkg::OFF_PC_DATA, 16'h0fca);
		$display("test port c done");
	endtask
	initial
	begin
		#80000;
		bad_count++;
		end_sim;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_port_b;
		t_port_c;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		t_reset;
		end_sim;
	end
endmodule
